// file: design/fpbl_defs.vh
// Constants for the flash status and boot lock host controller
`ifndef FPBL_DEFS_VH
`define FPBL_DEFS_VH
// Register word addresses (byte offsets)
`define FPBL_REG_CTRL     8'h00
`define FPBL_REG_ADDR     8'h04
`define FPBL_REG_WDATA    8'h08
`define FPBL_REG_RDATA    8'h0C
`define FPBL_REG_STATUS   8'h10
`define FPBL_REG_IRQ_STAT 8'h14
`define FPBL_REG_IRQ_MASK 8'h18
// Command codes in control bits 2:0
`define FPBL_CMD_READ     3'h1
`define FPBL_CMD_WRITE    3'h2
`define FPBL_CMD_POLL     3'h3
`define FPBL_CMD_TOGGLE   3'h4
// Event bits
`define FPBL_EV_DONE      0
`define FPBL_EV_POLLED    1
`define FPBL_EV_PWRUP     2
// Lockout detection bytes and addresses
`define FPBL_LOCK_FREE    8'hFE
`define FPBL_LOCK_SET     8'hFF
`define FPBL_BOOT_LO_ADDR 19'h00002
`define FPBL_BOOT_HI_ADDR 19'h7FFF2
// Timing
`define FPBL_CLK_MHZ      100
`define FPBL_PWRUP_MS     20
`define FPBL_PWRUP_CYC    (`FPBL_PWRUP_MS * 1000 * `FPBL_CLK_MHZ)
`define FPBL_TACC_NS      250
`define FPBL_TACC_CYC     ((`FPBL_TACC_NS * `FPBL_CLK_MHZ + 999) / 1000)
`define FPBL_TWP_NS       200
`define FPBL_TWP_CYC      ((`FPBL_TWP_NS * `FPBL_CLK_MHZ + 999) / 1000)
`define FPBL_TDF_NS       60
`define FPBL_TDF_CYC      ((`FPBL_TDF_NS * `FPBL_CLK_MHZ + 999) / 1000)
`endif

// file: design/fpbl_host.v
// Wishbone host controller driving a parallel flash through its pins
`timescale 1ns/1ps
`include "fpbl_defs.vh"
module fpbl_host #(
  parameter PWRUP_CYC = `FPBL_PWRUP_CYC,
  parameter POLL_MAX  = 32'h00FFFFFF
) (
  input  wire        clock_in,
  input  wire        rst_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [7:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  output wire        irq_out,
  output reg  [18:0] byte_address_bus_out,
  output reg         chip_sel_n_out,
  output reg         out_en_n_out,
  output reg         write_en_n_out,
  output reg  [7:0]  data_out,
  output reg         data_oe_out,
  input  wire [7:0]  data_in
);
  // ***************************************************
  // States
  // ***************************************************
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_RD   = 6'h02;
  localparam [5:0] S_WR   = 6'h04;
  localparam [5:0] S_GAP  = 6'h08;
  localparam [5:0] S_EVAL = 6'h10;
  localparam [5:0] S_PWR  = 6'h20;

  wire [7:0]  pin_sync;
  reg  [5:0]  state_r;
  reg  [2:0]  cmd_r;
  reg  [18:0] addr_r;
  reg  [7:0]  wdata_r;
  reg  [7:0]  rdata_r;
  reg  [7:0]  prev_r;
  reg         prev_ok_r;
  reg         fail_r;
  reg         busy_r;
  reg  [2:0]  irq_stat_r;
  reg  [2:0]  irq_mask_r;
  reg  [31:0] cnt_r;
  reg  [31:0] polls_r;
  reg  [2:0]  ev_set;
  wire        wb_hit;
  wire        poll_done;

  fpbl_pin_sync #(
    .WIDTH (8)
  ) u_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .async_in (data_in),
    .sync_out (pin_sync)
  );

  // Register address match
  function is_reg;
    input [7:0] adr;
    input [7:0] off;
    begin
      is_reg = (adr == off);
    end
  endfunction

  assign wb_hit = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign irq_out = |(irq_stat_r & irq_mask_r);

  assign poll_done = (cmd_r == `FPBL_CMD_POLL) ? (rdata_r[7] == wdata_r[7]) :
                     (prev_ok_r & (rdata_r[6] == prev_r[6]));

  // ***************************************************
  // Bus slave and interrupt status
  // ***************************************************
  always @(posedge clock_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
      addr_r     <= 19'h00000;
      wdata_r    <= 8'h00;
      irq_mask_r <= 3'h0;
      irq_stat_r <= 3'h0;
    end else begin
      wb_ack_out <= wb_hit;
      irq_stat_r <= irq_stat_r | ev_set;
      if (wb_hit && wb_we_in) begin
        if (is_reg(wb_adr_in, `FPBL_REG_ADDR) && wb_sel_in[0])
          addr_r <= wb_dat_in[18:0];
        if (is_reg(wb_adr_in, `FPBL_REG_WDATA) && wb_sel_in[0])
          wdata_r <= wb_dat_in[7:0];
        if (is_reg(wb_adr_in, `FPBL_REG_IRQ_MASK) && wb_sel_in[0])
          irq_mask_r <= wb_dat_in[2:0];
        // Set wins over write-one clear
        if (is_reg(wb_adr_in, `FPBL_REG_IRQ_STAT) && wb_sel_in[0])
          irq_stat_r <= (irq_stat_r & ~wb_dat_in[2:0]) | ev_set;
      end
      if (wb_hit && !wb_we_in) begin
        case (wb_adr_in)
          `FPBL_REG_CTRL:     wb_dat_out <= {29'h0, cmd_r};
          `FPBL_REG_ADDR:     wb_dat_out <= {13'h0, addr_r};
          `FPBL_REG_WDATA:    wb_dat_out <= {24'h0, wdata_r};
          `FPBL_REG_RDATA:    wb_dat_out <= {24'h0, rdata_r};
          `FPBL_REG_STATUS:   wb_dat_out <= {30'h0, fail_r, busy_r};
          `FPBL_REG_IRQ_STAT: wb_dat_out <= {29'h0, irq_stat_r};
          `FPBL_REG_IRQ_MASK: wb_dat_out <= {29'h0, irq_mask_r};
          default:            wb_dat_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ***************************************************
  // Pin sequencer
  // ***************************************************
  always @(posedge clock_in) begin
    if (rst_in) begin
      state_r              <= S_PWR;
      cmd_r                <= 3'h0;
      cnt_r                <= 32'h0000_0000;
      polls_r              <= 32'h0000_0000;
      busy_r               <= 1'b1;
      fail_r               <= 1'b0;
      rdata_r              <= 8'h00;
      prev_r               <= 8'h00;
      prev_ok_r            <= 1'b0;
      byte_address_bus_out <= 19'h00000;
      chip_sel_n_out       <= 1'b1;
      out_en_n_out         <= 1'b1;
      write_en_n_out       <= 1'b1;
      data_out             <= 8'h00;
      data_oe_out          <= 1'b0;
      ev_set               <= 3'h0;
    end else begin
      ev_set <= 3'h0;
      case (state_r)
        S_PWR: begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r >= PWRUP_CYC - 1) begin
            state_r <= S_IDLE;
            busy_r  <= 1'b0;
            ev_set[`FPBL_EV_PWRUP] <= 1'b1;
          end
        end
        S_IDLE: begin
          if (wb_hit && wb_we_in && is_reg(wb_adr_in, `FPBL_REG_CTRL) &&
              wb_sel_in[0] && (wb_dat_in[2:0] != 3'h0)) begin
            cmd_r                <= wb_dat_in[2:0];
            busy_r               <= 1'b1;
            fail_r               <= 1'b0;
            prev_ok_r            <= 1'b0;
            polls_r              <= 32'h0000_0000;
            cnt_r                <= 32'h0000_0000;
            byte_address_bus_out <= addr_r;
            chip_sel_n_out       <= 1'b0;
            // One byte load of a command series
            if (wb_dat_in[2:0] == `FPBL_CMD_WRITE) begin
              state_r        <= S_WR;
              write_en_n_out <= 1'b0;
              data_out       <= wdata_r;
              data_oe_out    <= 1'b1;
            end else begin
              state_r      <= S_RD;
              out_en_n_out <= 1'b0;
            end
          end
        end
        S_WR: begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r >= `FPBL_TWP_CYC - 1) begin
            write_en_n_out <= 1'b1;
            chip_sel_n_out <= 1'b1;
            cnt_r          <= 32'h0000_0000;
            state_r        <= S_GAP;
          end
        end
        S_RD: begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r >= `FPBL_TACC_CYC + 1) begin
            rdata_r        <= pin_sync;
            out_en_n_out   <= 1'b1;
            chip_sel_n_out <= 1'b1;
            cnt_r          <= 32'h0000_0000;
            state_r        <= S_EVAL;
          end
        end
        S_EVAL: begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r >= `FPBL_TDF_CYC - 1) begin
            cnt_r   <= 32'h0000_0000;
            prev_r  <= rdata_r;
            prev_ok_r <= 1'b1;
            polls_r <= polls_r + 32'h1;
            if ((cmd_r == `FPBL_CMD_POLL) || (cmd_r == `FPBL_CMD_TOGGLE)) begin
              if (poll_done) begin
                state_r <= S_IDLE;
                busy_r  <= 1'b0;
                ev_set[`FPBL_EV_POLLED] <= 1'b1;
              end else if (polls_r >= POLL_MAX) begin
                state_r <= S_IDLE;
                busy_r  <= 1'b0;
                fail_r  <= 1'b1;
                ev_set[`FPBL_EV_POLLED] <= 1'b1;
              end else begin
                state_r              <= S_RD;
                chip_sel_n_out       <= 1'b0;
                out_en_n_out         <= 1'b0;
              end
            end else begin
              state_r <= S_IDLE;
              busy_r  <= 1'b0;
              ev_set[`FPBL_EV_DONE] <= 1'b1;
            end
          end
        end
        S_GAP: begin
          data_oe_out <= 1'b0;
          state_r     <= S_IDLE;
          busy_r      <= 1'b0;
          ev_set[`FPBL_EV_DONE] <= 1'b1;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// file: design/fpbl_pin_sync.v
// Two-stage synchroniser for the flash data pins
`timescale 1ns/1ps
module fpbl_pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             clock_in,
  input  wire             rst_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  always @(posedge clock_in) begin
    if (rst_in) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end
  assign sync_out = sync_r;
endmodule

// file: verif/fpbl_flash_model.sv
// Behavioural model of the parallel flash
`timescale 1ns/1ps
module fpbl_flash_model #(
  parameter LOAD_NS = 50,
  parameter BUSY_NS = 3000,
  parameter ERASE_ADDR = 19'h00555,
  parameter ERASE_KEY  = 8'h10
) (
  input  wire        cs_n_in,
  input  wire        oe_n_in,
  input  wire        we_n_in,
  input  wire [18:0] addr_in,
  input  wire [7:0]  din_in,
  input  wire        lock_lo_in,
  input  wire        lock_hi_in,
  input  wire        ident_in,
  output logic [7:0] dq_out
);
  logic [7:0] mem [int];
  logic [7:0] last_b = 8'h00;
  logic       busy = 1'b0;
  logic       tgl = 1'b0;
  time        t_ld = 0;
  wire        wr_act = !cs_n_in && !we_n_in;
  wire        rd_act = !cs_n_in && !oe_n_in;
  initial dq_out = 8'h00;
  // erase key, ignored while any region is locked
  always @(negedge wr_act) begin
    if (addr_in == ERASE_ADDR && din_in == ERASE_KEY) begin
      if (!lock_lo_in && !lock_hi_in) mem.delete();
    end else if (!((addr_in < 19'h04000 && lock_lo_in) ||
                   (addr_in >= 19'h7C000 && lock_hi_in)))
      mem[addr_in] = din_in;
    last_b = din_in;
    t_ld = $time;
  end
  // idle after last load starts programming
  always #10 if (t_ld > 0 && $time - t_ld >= LOAD_NS) begin
    t_ld = 0;
    busy = 1'b1;
    #BUSY_NS busy = 1'b0;
  end
  always @(negedge rd_act) tgl = ~tgl;
  always @(cs_n_in, oe_n_in, busy, tgl, addr_in, ident_in) begin
    if (cs_n_in || oe_n_in) dq_out = ~dq_out;
    else if (busy) dq_out = {~last_b[7], tgl, last_b[5:0]};
    else if (ident_in && addr_in == 19'h00002) dq_out = {7'h7F, lock_lo_in};
    else if (ident_in && addr_in == 19'h7FFF2) dq_out = {7'h7F, lock_hi_in};
    else if (mem.exists(addr_in)) dq_out = mem[addr_in];
    else dq_out = 8'hFF;
  end
endmodule

// file: verif/fpbl_host_properties.sv
// Port assertions for the flash host controller
`timescale 1ns/1ps
module fpbl_host_properties (
  input wire        clock_in,
  input wire        rst_in,
  input wire        wb_cyc_in,
  input wire        wb_stb_in,
  input wire        wb_ack_out,
  input wire        chip_sel_n_out,
  input wire        out_en_n_out,
  input wire        write_en_n_out,
  input wire        data_oe_out
);
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing");
  a_no_contend: assert property (data_oe_out |-> out_en_n_out)
    else $error("bus contention");
  a_prog_mode: assert property (!write_en_n_out |-> out_en_n_out && !chip_sel_n_out)
    else $error("bad program strobes");
  a_we_width: assert property ($fell(write_en_n_out) |-> ##19 !write_en_n_out ##1 write_en_n_out)
    else $error("write pulse width");
  a_oe_release: assert property ($rose(write_en_n_out) |-> data_oe_out ##1 !data_oe_out)
    else $error("data release");
  a_read_width: assert property ($fell(out_en_n_out) |-> ##26 !out_en_n_out ##1 out_en_n_out)
    else $error("read width");
  a_float_gap: assert property ($rose(out_en_n_out) |-> out_en_n_out [*6])
    else $error("float gap");
  c_load: cover property ($fell(write_en_n_out));
  c_read: cover property ($fell(out_en_n_out));
  c_bus: cover property (wb_ack_out);
endmodule
bind fpbl_host fpbl_host_properties fpbl_host_properties_inst (
  .clock_in(clock_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_ack_out(wb_ack_out), .chip_sel_n_out(chip_sel_n_out), .out_en_n_out(out_en_n_out),
  .write_en_n_out(write_en_n_out), .data_oe_out(data_oe_out));

// file: verif/fpbl_host_tb.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`include "fpbl_defs.vh"
module fpbl_host_tb;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, lk = 1'b0, idn = 1'b0, lkh = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic [2:0]  msk = 3'h0;
  wire  [31:0] dat;
  wire         ack, irq, cs_n, oe_n, we_n, doe;
  wire  [18:0] fa;
  wire  [7:0]  dh, df;
  integer      error_cnt = 0, comparisons = 0, i, k;
  logic [7:0]  ra [4] = '{`FPBL_REG_ADDR, `FPBL_REG_WDATA, `FPBL_REG_IRQ_MASK, 8'h40};
  logic [31:0] rw [4] = '{32'h7FFF2, 32'hA5, 32'h3, 32'h5};
  logic [31:0] re [4] = '{32'h7FFF2, 32'hA5, 32'h3, 32'h0};
  logic [18:0] la [2] = '{19'h00010, 19'h7C010};
  logic [31:0] le [2] = '{32'hFF, 32'h33};
  always #5 clock_in = ~clock_in;
  fpbl_host #(.PWRUP_CYC(50), .POLL_MAX(64)) fpbl_host_inst (
    .clock_in(clock_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wd), .wb_dat_out(dat), .wb_ack_out(ack),
    .irq_out(irq), .byte_address_bus_out(fa), .chip_sel_n_out(cs_n), .out_en_n_out(oe_n),
    .write_en_n_out(we_n), .data_out(dh), .data_oe_out(doe), .data_in(doe ? dh : df));
  fpbl_flash_model #(.LOAD_NS(50), .BUSY_NS(3000)) fpbl_flash_model_inst (
    .cs_n_in(cs_n), .oe_n_in(oe_n), .we_n_in(we_n), .addr_in(fa), .din_in(dh),
    .lock_lo_in(lk), .lock_hi_in(lkh), .ident_in(idn), .dq_out(df));
  task stop_test;
    begin
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      comparisons++;
      if (g !== e) begin
        error_cnt++;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wbt(input [7:0] a, input w, input [31:0] d);
    begin
      adr <= a;
      we <= w;
      wd <= d;
      cyc <= 1'b1;
      stb <= 1'b1;
      k = 0;
      do begin
        @(posedge clock_in);
        k++;
      end while (ack !== 1'b1 && k < 20);
      rd = dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clock_in);
      if (k >= 20) begin
        error_cnt++;
        stop_test;
      end
    end
  endtask
  task run(input [2:0] op, input [18:0] a, input [7:0] d);
    integer j;
    begin
      wbt(`FPBL_REG_ADDR, 1'b1, {13'h0, a});
      wbt(`FPBL_REG_WDATA, 1'b1, {24'h0, d});
      wbt(`FPBL_REG_CTRL, 1'b1, {29'h0, op});
      j = 0;
      do begin
        wbt(`FPBL_REG_IRQ_STAT, 1'b0, 32'h0);
        j++;
      end while (rd[1:0] === 2'b00 && j < 400);
      if (j >= 400) begin
        error_cnt++;
        stop_test;
      end
      chk("irq", {31'h0, |(rd[2:0] & msk)}, {31'h0, irq});
      wbt(`FPBL_REG_IRQ_STAT, 1'b1, 32'h7);
    end
  endtask
  task rdb(input [18:0] a);
    begin
      run(`FPBL_CMD_READ, a, 8'h00);
      wbt(`FPBL_REG_RDATA, 1'b0, 32'h0);
    end
  endtask
  initial begin
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    i = 0;
    do begin
      wbt(`FPBL_REG_STATUS, 1'b0, 32'h0);
      i++;
    end while (rd[0] !== 1'b0 && i < 100);
    if (i >= 100) begin
      error_cnt++;
      stop_test;
    end
    wbt(`FPBL_REG_IRQ_STAT, 1'b0, 32'h0);
    chk("pwrup", 32'h4, {29'h0, rd[2:0]});
    wbt(`FPBL_REG_IRQ_STAT, 1'b1, 32'h7);
    for (i = 0; i < 4; i++) begin
      wbt(ra[i], 1'b1, rw[i]);
      wbt(ra[i], 1'b0, 32'h0);
      chk("reg", re[i], rd);
    end
    msk = 3'h3;
    run(`FPBL_CMD_WRITE, 19'h00100, 8'h5A);
    run(`FPBL_CMD_POLL, 19'h00100, 8'h5A);
    rdb(19'h00100);
    chk("data", 32'h5A, {24'h0, rd[7:0]});
    wbt(`FPBL_REG_IRQ_MASK, 1'b1, 32'h0);
    msk = 3'h0;
    run(`FPBL_CMD_WRITE, 19'h00200, 8'hC3);
    run(`FPBL_CMD_TOGGLE, 19'h00200, 8'h00);
    rdb(19'h00200);
    chk("data", 32'hC3, {24'h0, rd[7:0]});
    lk <= 1'b1;
    idn <= 1'b1;
    rdb(`FPBL_BOOT_LO_ADDR);
    chk("lock_lo", 32'hFF, {24'h0, rd[7:0]});
    rdb(`FPBL_BOOT_HI_ADDR);
    chk("lock_hi", 32'hFE, {24'h0, rd[7:0]});
    idn <= 1'b0;
    for (i = 0; i < 2; i++) begin
      run(`FPBL_CMD_WRITE, la[i], 8'h33);
      run(`FPBL_CMD_TOGGLE, la[i], 8'h00);
      rdb(la[i]);
      chk("boot", le[i], {24'h0, rd[7:0]});
    end
    lkh <= 1'b1;
    idn <= 1'b1;
    rdb(`FPBL_BOOT_HI_ADDR);
    chk("lock_hi", 32'hFF, {24'h0, rd[7:0]});
    idn <= 1'b0;
    run(`FPBL_CMD_WRITE, 19'h00555, 8'h10);
    run(`FPBL_CMD_TOGGLE, 19'h7C010, 8'h00);
    rdb(19'h7C010);
    chk("erase", 32'h33, {24'h0, rd[7:0]});
    rst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    wbt(`FPBL_REG_STATUS, 1'b0, 32'h0);
    chk("rst_busy", 32'h1, rd);
    stop_test;
  end
endmodule
